// file: bench/ipm_core_model.sv
`timescale 1ns/1ps
module ipm_core_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       go,
   input  wire logic [3:0] lag,
   input  wire logic       irq_req,
   output logic            ack
);
   logic [3:0] wait_cnt;
   // the dropped ack cycle keeps acks two cycles apart; lag gives slow takes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (ack || !irq_req || !go) begin
         ack <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (wait_cnt == lag) begin
         ack <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule // ipm_core_model

// file: bench/ipm_top_tb.sv
`timescale 1ns/1ps
module ipm_top_tb;
   logic        mclk = 1'b0;
   logic        arst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [13:0] fl = 14'h0000;
   logic        p0_n = 1'b1;
   logic        p1_n = 1'b1;
   logic        reti = 1'b0;
   logic        c_ale = 1'b0;
   logic        c_ps_n = 1'b0;
   logic        go = 1'b1;
   logic [15:0] rdata, vec, d;
   logic        ack, req, halt, crun, ale, ps_n, evt;
   logic [1:0]  lvl;
   logic [9:0]  srv;
   int          fail_count = 0;
   int          n_checks = 0;
   int          cyc = 0;
   always #5 mclk = ~mclk;
   ipm_top ipm_top_i (.MCLK(mclk), .ARST_N(arst_n), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .EXT_IRQ0_FLAG(fl[0]), .BROWNOUT_DET(fl[1]),
      .TIMER_A_OVERFLOW(fl[2]), .EXT_IRQ1_FLAG(fl[3]),
      .TIMER_B_OVERFLOW(fl[4]), .COUNTER_ARRAY_OVERFLOW(fl[5]),
      .EXT_IRQ2_FLAG(fl[6]), .EXT_IRQ3_FLAG(fl[7]), .TX_DONE_FLAG(fl[8]),
      .TIMER_C_OVERFLOW(fl[9]), .RX_DONE_FLAG(fl[10]),
      .SYNC_SERIAL_COMPLETE(fl[11]), .TIMER_C_EXT_TRIGGER(fl[12]),
      .COUNTER_ARRAY_MODULE_FLAG({4'h0, fl[13]}),
      .EXT_INT0_PIN_N(p0_n), .EXT_INT1_PIN_N(p1_n), .CORE_ACK(ack),
      .CORE_RETI(reti), .CORE_ALE(c_ale),
      .CORE_PROGRAM_STORE_STROBE_N(c_ps_n), .IRQ_REQ(req),
      .IRQ_VECTOR(vec), .IRQ_LEVEL(lvl), .SERVICED(srv), .CPU_HALT(halt),
      .CLK_RUN(crun), .ALE(ale), .PROGRAM_STORE_STROBE_N(ps_n),
      .EVT_IRQ(evt));
   ipm_core_model ipm_core_model_i (.clk(mclk), .rst_n(arst_n), .go(go),
      .lag(4'h2), .irq_req(req), .ack(ack));
   // =========================================================
   // bus and compare helpers
   // =========================================================
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wait_req();
      for (int i = 0; i < 40 && req !== 1'b1; i++) tick(1);
   endtask
   task automatic wait_srv();
      for (int i = 0; i < 40 && srv === 10'h000; i++) tick(1);
   endtask
   task automatic ret();
      @(posedge mclk);
      reti <= 1'b1;
      @(posedge mclk);
      reti <= 1'b0;
   endtask
   // =========================================================
   // scenarios
   // =========================================================
   task automatic t_reset();
      chk(crun, 16'h0001);
      chk(halt, 16'h0000);
      rreg(4'hF);
      chk(d, 16'h0000);
   endtask
   task automatic t_vectors();
      logic [15:0] vt[10] = '{16'h0003, 16'h004B, 16'h000B, 16'h0013,
         16'h001B, 16'h0033, 16'h003B, 16'h0043, 16'h0023, 16'h002B};
      int ix[14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 8, 8, 9, 5};
      for (int k = 0; k < 14; k++) begin
         // rewriting the enable also drops brown-out enable after service
         wreg(4'h0, 16'h8000 | (16'h0001 << ix[k]));
         fl[k] <= 1'b1;
         wait_req();
         chk(vec, vt[ix[k]]);
         wait_srv();
         chk(srv, 16'h0001 << ix[k]);
         fl[k] <= 1'b0;
         ret();
      end
   endtask
   task automatic t_prio();
      go <= 1'b0;
      wreg(4'h0, 16'h03FF);
      fl <= 14'h0204;
      tick(6);
      chk(req, 16'h0000);
      wreg(4'h0, 16'h83FF);
      wreg(4'h1, 16'h0200);
      wreg(4'h2, 16'h0200);
      tick(3);
      chk(vec, 16'h002B);
      chk(lvl, 16'h0003);
      wreg(4'h1, 16'h0000);
      wreg(4'h2, 16'h0000);
      tick(3);
      chk(vec, 16'h000B);
      go <= 1'b1;
      wait_srv();
      fl <= 14'h0200;
      wreg(4'h1, 16'h0200);
      wreg(4'h2, 16'h0200);
      wait_req();
      chk(vec, 16'h002B);
      // the preemption flag is only set at the ack edge
      wait_srv();
      rreg(4'h4);
      chk(d & 16'h0004, 16'h0004);
      fl <= 14'h0000;
      ret();
      ret();
   endtask
   task automatic t_idle();
      wreg(4'h0, 16'h8004);
      wreg(4'h3, 16'h0001);
      tick(1);
      chk({halt, crun, ale, ps_n}, 16'h000F);
      rreg(4'h0);
      chk(d, 16'h8004);
      fl[2] <= 1'b1;
      wait_req();
      chk(vec, 16'h000B);
      wait_srv();
      tick(1);
      chk(halt, 16'h0000);
      rreg(4'h3);
      chk(d, 16'h0000);
      wreg(4'h5, 16'h0002);
      tick(2);
      chk(evt, 16'h0001);
      wreg(4'h4, 16'h0007);
      tick(2);
      chk(evt, 16'h0000);
      fl[2] <= 1'b0;
      ret();
   endtask
   task automatic t_pdown();
      c_ale <= 1'b1;
      c_ps_n <= 1'b1;
      wreg(4'h0, 16'h8005);
      wreg(4'h3, 16'h0002);
      fl[2] <= 1'b1;
      tick(8);
      chk({req, crun, ale, ps_n}, 16'h0000);
      fl[2] <= 1'b0;
      p0_n <= 1'b0;
      tick(500);
      p0_n <= 1'b1;
      tick(6);
      chk(crun, 16'h0000);
      p0_n <= 1'b0;
      tick(1030);
      p0_n <= 1'b1;
      wait_req();
      chk(crun, 16'h0001);
      chk(vec, 16'h0003);
      wait_srv();
      rreg(4'h3);
      chk(d, 16'h0000);
      ret();
      wreg(4'h3, 16'h0001);
      arst_n <= 1'b0;
      tick(2);
      chk({halt, crun}, 16'h0001);
      chk({ale, ps_n}, 16'h0003);
      arst_n <= 1'b1;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      tick(1);
      t_reset();
      t_vectors();
      t_prio();
      t_idle();
      t_pdown();
      final_report();
   end
endmodule // ipm_top_tb

// file: hw/ipm_arb_if.sv
`timescale 1ns/1ps
interface ipm_arb_if;
   logic [9:0]  req;
   logic [19:0] lvl;
   logic        busy;
   logic [1:0]  ceil;
   logic        win_valid;
   logic [3:0]  win_idx;
   logic [1:0]  win_lvl;

   modport arb (input req, lvl, busy, ceil,
                output win_valid, win_idx, win_lvl);
   modport ctl (output req, lvl, busy, ceil,
                input win_valid, win_idx, win_lvl);
endinterface

// file: hw/ipm_arbiter.sv
`timescale 1ns/1ps
module ipm_arbiter (
   ipm_arb_if.arb a
);
   logic       found;
   logic [1:0] best;
   logic [3:0] idx;

   // =========================================================
   // pick highest level; lower index wins a tie
   // =========================================================
   always_comb begin
      found = 1'b0;
      best  = 2'b00;
      idx   = 4'h0;
      for (int i = 0; i < ipm_pkg::NSRC; i++) begin
         if (a.req[i] && (!found || a.lvl[2*i +: 2] > best)) begin
            found = 1'b1;
            best  = a.lvl[2*i +: 2];
            idx   = 4'(i);
         end
      end
   end

   // only a strictly higher level may preempt what is in service
   assign a.win_valid = found && (!a.busy || best > a.ceil);
   assign a.win_idx   = idx;
   assign a.win_lvl   = best;
endmodule // ipm_arbiter

// file: hw/ipm_pkg.sv
package ipm_pkg;

   // =========================================================
   // sources, in fixed order among equal levels (index 0 served first)
   // =========================================================
   localparam int NSRC        = 10;
   localparam int SRC_EXT0    = 0;
   localparam int SRC_BROWN   = 1;
   localparam int SRC_TIMER_A = 2;
   localparam int SRC_EXT1    = 3;
   localparam int SRC_TIMER_B = 4;
   localparam int SRC_CARRAY  = 5;
   localparam int SRC_EXT2    = 6;
   localparam int SRC_EXT3    = 7;
   localparam int SRC_SERIAL  = 8;
   localparam int SRC_TIMER_C = 9;

   // =========================================================
   // vectors
   // =========================================================
   localparam logic [15:0] VEC_EXT0    = 16'h0003;
   localparam logic [15:0] VEC_BROWN   = 16'h004B;
   localparam logic [15:0] VEC_TIMER_A = 16'h000B;
   localparam logic [15:0] VEC_EXT1    = 16'h0013;
   localparam logic [15:0] VEC_TIMER_B = 16'h001B;
   localparam logic [15:0] VEC_CARRAY  = 16'h0033;
   localparam logic [15:0] VEC_EXT2    = 16'h003B;
   localparam logic [15:0] VEC_EXT3    = 16'h0043;
   localparam logic [15:0] VEC_SERIAL  = 16'h0023;
   localparam logic [15:0] VEC_TIMER_C = 16'h002B;

   // =========================================================
   // register map (word index on REG_ADDR)
   // =========================================================
   localparam logic [3:0] REG_ENABLE    = 4'h0;
   localparam logic [3:0] REG_PRIO_LO   = 4'h1;
   localparam logic [3:0] REG_PRIO_HI   = 4'h2;
   localparam logic [3:0] REG_POWER_CONTROL_REG      = 4'h3;
   localparam logic [3:0] REG_STATUS    = 4'h4;
   localparam logic [3:0] REG_MASK      = 4'h5;
   localparam logic [3:0] REG_INSERVICE = 4'h6;

   localparam int ENA_EXT0_EDGE = 10;
   localparam int ENA_EXT1_EDGE = 11;
   localparam int ENA_GLOBAL    = 15;
   localparam int POWER_CONTROL_REG_IDLE     = 0;
   localparam int POWER_CONTROL_REG_PDOWN    = 1;
   localparam int EVT_WAKE      = 0;
   localparam int EVT_IDLE_EXIT = 1;
   localparam int EVT_PREEMPT   = 2;
   localparam int INS_REQ       = 4;
   localparam int INS_IDX_LSB   = 8;

   localparam logic [15:0] RST_VAL = 16'h0000;

   // pin must stay low this many clocks before a wake counts
   localparam logic [10:0] WAKE_LOW_CYCLES = 11'd1024;

   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_IDLE,
      MODE_PDOWN
   } ipm_mode_t;

   function automatic logic [15:0] vector_of(input logic [3:0] idx);
      case (idx)
         4'd0:    vector_of = VEC_EXT0;
         4'd1:    vector_of = VEC_BROWN;
         4'd2:    vector_of = VEC_TIMER_A;
         4'd3:    vector_of = VEC_EXT1;
         4'd4:    vector_of = VEC_TIMER_B;
         4'd5:    vector_of = VEC_CARRAY;
         4'd6:    vector_of = VEC_EXT2;
         4'd7:    vector_of = VEC_EXT3;
         4'd8:    vector_of = VEC_SERIAL;
         default: vector_of = VEC_TIMER_C;
      endcase
   endfunction

   // highest level now in service; valid low when none
   function automatic logic [2:0] top_level(input logic [3:0] act);
      if (act[3])      top_level = 3'b111;
      else if (act[2]) top_level = 3'b110;
      else if (act[1]) top_level = 3'b101;
      else if (act[0]) top_level = 3'b100;
      else             top_level = 3'b000;
   endfunction

endpackage

// file: hw/ipm_top.sv
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// Function
// - four levels; higher level preempts lower
// - fixed order among equal levels
// - each source jumps to its own vector
// - serial and sync-serial share vector 0023H
// - power-down: only ext 0/1 level wake
// - idle bit halts program, clock runs
// - idle keeps state, strobes driven high
// - interrupt start clears idle bit
// - hardware reset ends idle and power-down
// - power-down bit stops the clock
// - power-down keeps state, strobes driven low
// - level ext wake clears power-down before the interrupt starts
// - pin low 1024 clocks, serve on release
module ipm_top (
   input  wire logic        MCLK,
   input  wire logic        ARST_N,
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [15:0]      REG_RDATA,
   input  wire logic        EXT_IRQ0_FLAG,
   input  wire logic        EXT_IRQ1_FLAG,
   input  wire logic        EXT_IRQ2_FLAG,
   input  wire logic        EXT_IRQ3_FLAG,
   input  wire logic        BROWNOUT_DET,
   input  wire logic        TIMER_A_OVERFLOW,
   input  wire logic        TIMER_B_OVERFLOW,
   input  wire logic        TIMER_C_OVERFLOW,
   input  wire logic        TIMER_C_EXT_TRIGGER,
   input  wire logic        COUNTER_ARRAY_OVERFLOW,
   input  wire logic [4:0]  COUNTER_ARRAY_MODULE_FLAG,
   input  wire logic        TX_DONE_FLAG,
   input  wire logic        RX_DONE_FLAG,
   input  wire logic        SYNC_SERIAL_COMPLETE,
   input  wire logic        EXT_INT0_PIN_N,
   input  wire logic        EXT_INT1_PIN_N,
   input  wire logic        CORE_ACK,
   input  wire logic        CORE_RETI,
   input  wire logic        CORE_ALE,
   input  wire logic        CORE_PROGRAM_STORE_STROBE_N,
   output logic             IRQ_REQ,
   output logic [15:0]      IRQ_VECTOR,
   output logic [1:0]       IRQ_LEVEL,
   output logic [9:0]       SERVICED,
   output logic             CPU_HALT,
   output logic             CLK_RUN,
   output logic             ALE,
   output logic             PROGRAM_STORE_STROBE_N,
   output logic             EVT_IRQ
);
   ipm_arb_if arb ();

   logic [15:0]        enable_r;
   logic [15:0]        prio_lo;
   logic [15:0]        prio_hi;
   logic [15:0]        status;
   logic [15:0]        mask;
   ipm_pkg::ipm_mode_t mode;
   logic [3:0]         active;
   logic [3:0]         idx_q;
   logic [1:0]         wake_pend;
   logic [9:0]         raw;
   logic [2:0]         top;
   logic               ack;
   logic               wake;
   logic [1:0]         wake_src;
   logic [1:0]         wake_allow;
   logic [2:0]         events;
   logic               global_en;

   // =========================================================
   // source requests
   // =========================================================
   assign global_en = enable_r[ipm_pkg::ENA_GLOBAL];

   always_comb begin
      raw = '0;
      raw[ipm_pkg::SRC_EXT0]    = EXT_IRQ0_FLAG | wake_pend[0];
      raw[ipm_pkg::SRC_BROWN]   = BROWNOUT_DET;
      raw[ipm_pkg::SRC_TIMER_A] = TIMER_A_OVERFLOW;
      raw[ipm_pkg::SRC_EXT1]    = EXT_IRQ1_FLAG | wake_pend[1];
      raw[ipm_pkg::SRC_TIMER_B] = TIMER_B_OVERFLOW;
      raw[ipm_pkg::SRC_CARRAY]  = COUNTER_ARRAY_OVERFLOW |
                                  (|COUNTER_ARRAY_MODULE_FLAG);
      raw[ipm_pkg::SRC_EXT2]    = EXT_IRQ2_FLAG;
      raw[ipm_pkg::SRC_EXT3]    = EXT_IRQ3_FLAG;
      raw[ipm_pkg::SRC_SERIAL]  = TX_DONE_FLAG | RX_DONE_FLAG |
                                  SYNC_SERIAL_COMPLETE;
      raw[ipm_pkg::SRC_TIMER_C] = TIMER_C_OVERFLOW |
                                  TIMER_C_EXT_TRIGGER;
   end

   // clock is stopped in power-down: nothing reaches the arbiter
   assign arb.req = (mode == ipm_pkg::MODE_PDOWN) ? 10'h000 :
                    raw & enable_r[9:0] & {10{global_en}};

   always_comb begin
      for (int i = 0; i < ipm_pkg::NSRC; i++)
         arb.lvl[2*i +: 2] = {prio_hi[i], prio_lo[i]};
   end

   assign top      = ipm_pkg::top_level(active);
   assign arb.busy = top[2];
   assign arb.ceil = top[1:0];

   ipm_arbiter u_arb (
      .a (arb)
   );

   // =========================================================
   // vector presentation to the core
   // =========================================================
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         IRQ_REQ    <= 1'b0;
         IRQ_VECTOR <= ipm_pkg::RST_VAL;
         IRQ_LEVEL  <= 2'b00;
         idx_q      <= 4'h0;
      end else begin
         IRQ_REQ    <= arb.win_valid && !ack;
         IRQ_VECTOR <= ipm_pkg::vector_of(arb.win_idx);
         IRQ_LEVEL  <= arb.win_lvl;
         idx_q      <= arb.win_idx;
      end
   end

   // a request is only taken while it is being presented
   assign ack = CORE_ACK && IRQ_REQ;

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N)
         SERVICED <= 10'h000;
      else if (ack)
         SERVICED <= 10'(10'h001 << idx_q);
      else
         SERVICED <= 10'h000;
   end

   // in-service levels; return drops the top one first
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         active <= 4'h0;
      end else begin
         for (int l = 0; l < 4; l++) begin
            if (ack && IRQ_LEVEL == 2'(l))
               active[l] <= 1'b1;
            else if (CORE_RETI && top[2] && top[1:0] == 2'(l))
               active[l] <= 1'b0;
         end
      end
   end

   // =========================================================
   // power modes
   // =========================================================
   assign wake_allow[0] = global_en &&
                          enable_r[ipm_pkg::SRC_EXT0] &&
                          !enable_r[ipm_pkg::ENA_EXT0_EDGE];
   assign wake_allow[1] = global_en &&
                          enable_r[ipm_pkg::SRC_EXT1] &&
                          !enable_r[ipm_pkg::ENA_EXT1_EDGE];

   ipm_wake u_wake (
      .clk      (MCLK),
      .rst_n    (ARST_N),
      .armed    (mode == ipm_pkg::MODE_PDOWN),
      .pin_n    ({EXT_INT1_PIN_N, EXT_INT0_PIN_N}),
      .allow    (wake_allow),
      .wake     (wake),
      .wake_src (wake_src)
   );

   // reset lands in run from any mode, as at power-on
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mode <= ipm_pkg::MODE_RUN;
      end else begin
         case (mode)
            ipm_pkg::MODE_RUN: begin
               if (REG_WR && REG_ADDR == ipm_pkg::REG_POWER_CONTROL_REG) begin
                  if (REG_WDATA[ipm_pkg::POWER_CONTROL_REG_PDOWN])
                     mode <= ipm_pkg::MODE_PDOWN;
                  else if (REG_WDATA[ipm_pkg::POWER_CONTROL_REG_IDLE])
                     mode <= ipm_pkg::MODE_IDLE;
               end
            end
            ipm_pkg::MODE_IDLE: begin
               if (ack)
                  mode <= ipm_pkg::MODE_RUN;
            end
            ipm_pkg::MODE_PDOWN: begin
               if (wake)
                  mode <= ipm_pkg::MODE_RUN;
            end
            default: mode <= ipm_pkg::MODE_RUN;
         endcase
      end
   end

   // the pin is high again by now, so the wake is held until served
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wake_pend <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wake && wake_src[i])
               wake_pend[i] <= 1'b1;
            else if (SERVICED[ipm_pkg::SRC_EXT0] && i == 0)
               wake_pend[i] <= 1'b0;
            else if (SERVICED[ipm_pkg::SRC_EXT1] && i == 1)
               wake_pend[i] <= 1'b0;
         end
      end
   end

   assign CPU_HALT = (mode != ipm_pkg::MODE_RUN);
   assign CLK_RUN  = (mode != ipm_pkg::MODE_PDOWN);

   always_comb begin
      case (mode)
         ipm_pkg::MODE_IDLE: begin
            ALE                    = 1'b1;
            PROGRAM_STORE_STROBE_N = 1'b1;
         end
         ipm_pkg::MODE_PDOWN: begin
            ALE                    = 1'b0;
            PROGRAM_STORE_STROBE_N = 1'b0;
         end
         default: begin
            ALE                    = CORE_ALE;
            PROGRAM_STORE_STROBE_N = CORE_PROGRAM_STORE_STROBE_N;
         end
      endcase
   end

   // =========================================================
   // software registers; contents survive idle and power-down
   // =========================================================
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         enable_r <= ipm_pkg::RST_VAL;
         prio_lo  <= ipm_pkg::RST_VAL;
         prio_hi  <= ipm_pkg::RST_VAL;
         mask     <= ipm_pkg::RST_VAL;
      end else if (REG_WR) begin
         if (REG_ADDR == ipm_pkg::REG_ENABLE)
            enable_r <= REG_WDATA;
         else if (REG_ADDR == ipm_pkg::REG_PRIO_LO)
            prio_lo <= REG_WDATA;
         else if (REG_ADDR == ipm_pkg::REG_PRIO_HI)
            prio_hi <= REG_WDATA;
         else if (REG_ADDR == ipm_pkg::REG_MASK)
            mask <= REG_WDATA;
      end
   end

   // =========================================================
   // sticky events, write one to clear; a new event wins
   // =========================================================
   always_comb begin
      events                         = 3'b000;
      events[ipm_pkg::EVT_WAKE]      = wake;
      events[ipm_pkg::EVT_IDLE_EXIT] = ack && mode == ipm_pkg::MODE_IDLE;
      events[ipm_pkg::EVT_PREEMPT]   = ack && top[2];
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         status <= ipm_pkg::RST_VAL;
      end else begin
         if (REG_WR && REG_ADDR == ipm_pkg::REG_STATUS)
            status <= (status & ~REG_WDATA) | {13'h0000, events};
         else
            status <= status | {13'h0000, events};
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N)
         EVT_IRQ <= 1'b0;
      else
         EVT_IRQ <= |(status & mask);
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         REG_RDATA <= ipm_pkg::RST_VAL;
      end else if (!REG_RD) begin
         REG_RDATA <= ipm_pkg::RST_VAL;
      end else if (REG_ADDR == ipm_pkg::REG_ENABLE) begin
         REG_RDATA <= enable_r;
      end else if (REG_ADDR == ipm_pkg::REG_PRIO_LO) begin
         REG_RDATA <= prio_lo;
      end else if (REG_ADDR == ipm_pkg::REG_PRIO_HI) begin
         REG_RDATA <= prio_hi;
      end else if (REG_ADDR == ipm_pkg::REG_POWER_CONTROL_REG) begin
         REG_RDATA <= ipm_pkg::RST_VAL;
         REG_RDATA[ipm_pkg::POWER_CONTROL_REG_IDLE]  <= (mode == ipm_pkg::MODE_IDLE);
         REG_RDATA[ipm_pkg::POWER_CONTROL_REG_PDOWN] <= (mode == ipm_pkg::MODE_PDOWN);
      end else if (REG_ADDR == ipm_pkg::REG_STATUS) begin
         REG_RDATA <= status;
      end else if (REG_ADDR == ipm_pkg::REG_MASK) begin
         REG_RDATA <= mask;
      end else if (REG_ADDR == ipm_pkg::REG_INSERVICE) begin
         REG_RDATA <= {4'h0, idx_q, 3'b000, IRQ_REQ, active};
      end else begin
         REG_RDATA <= ipm_pkg::RST_VAL;
      end
   end

   // =========================================================
   // checks
   // =========================================================
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!ARST_N);

   preempt_higher_a: assert property (
      ack && top[2] |-> IRQ_LEVEL > top[1:0])
      else $error("preemption by a level not above service level");

   ext0_first_a: assert property (
      arb.req[ipm_pkg::SRC_EXT0] && !arb.busy &&
      arb.lvl[1:0] == 2'b11 && !ack
      |=> IRQ_VECTOR == ipm_pkg::VEC_EXT0)
      else $error("ext 0 at top level not chosen first");

   serial_vector_a: assert property (
      arb.req == 10'h100 && !arb.busy && !ack
      |=> IRQ_REQ && IRQ_VECTOR == ipm_pkg::VEC_SERIAL)
      else $error("serial request not on its shared vector");

   pdown_quiet_a: assert property (
      mode == ipm_pkg::MODE_PDOWN |=> !IRQ_REQ || $past(wake))
      else $error("request presented while clock stopped");

   idle_strobes_a: assert property (
      mode == ipm_pkg::MODE_IDLE
      |-> ALE && PROGRAM_STORE_STROBE_N && CPU_HALT && CLK_RUN)
      else $error("idle strobes or clock wrong");

   pdown_strobes_a: assert property (
      mode == ipm_pkg::MODE_PDOWN
      |-> !ALE && !PROGRAM_STORE_STROBE_N && !CLK_RUN)
      else $error("power-down strobes or clock wrong");

   idle_exit_a: assert property (
      ack && mode == ipm_pkg::MODE_IDLE
      |=> mode == ipm_pkg::MODE_RUN && status[ipm_pkg::EVT_IDLE_EXIT])
      else $error("interrupt start left idle bit set");

   wake_serves_a: assert property (
      wake && wake_src[0] && !arb.busy |=> mode == ipm_pkg::MODE_RUN
      ##1 IRQ_REQ && IRQ_VECTOR == ipm_pkg::VEC_EXT0
          || $past(arb.req) != 10'h001)
      else $error("wake did not restart and present ext 0");

   global_gate_a: assert property (
      !global_en |=> !IRQ_REQ)
      else $error("request with global enable clear");

   carray_or_a: assert property (
      COUNTER_ARRAY_MODULE_FLAG != 5'h00 && global_en &&
      enable_r[ipm_pkg::SRC_CARRAY] && mode != ipm_pkg::MODE_PDOWN
      |-> arb.req[ipm_pkg::SRC_CARRAY])
      else $error("module flag did not raise counter array request");

endmodule // ipm_top

// file: hw/ipm_wake.sv
`timescale 1ns/1ps
module ipm_wake (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       armed,
   input  wire logic [1:0] pin_n,
   input  wire logic [1:0] allow,
   output logic            wake,
   output logic [1:0]      wake_src
);
   logic [10:0] low_cnt [2];
   logic [1:0]  ok;

   // =========================================================
   // low-time counters, one per wake-capable pin
   // =========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt[0] <= '0;
         low_cnt[1] <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!armed || pin_n[i] || !allow[i])
               low_cnt[i] <= '0;
            else if (low_cnt[i] != ipm_pkg::WAKE_LOW_CYCLES)
               low_cnt[i] <= low_cnt[i] + 11'd1;
         end
      end
   end

   // a pin released early restarts the count, no wake
   always_comb begin
      for (int i = 0; i < 2; i++)
         ok[i] = armed && allow[i] && pin_n[i] &&
                 low_cnt[i] == ipm_pkg::WAKE_LOW_CYCLES;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake     <= 1'b0;
         wake_src <= 2'b00;
      end else begin
         wake     <= |ok && !wake;
         wake_src <= ok;
      end
   end

   wake_needs_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(wake) |-> $past(low_cnt[0]) == ipm_pkg::WAKE_LOW_CYCLES ||
                      $past(low_cnt[1]) == ipm_pkg::WAKE_LOW_CYCLES)
      else $error("wake without 1024 low cycles");

   wake_only_armed_a: assert property (@(posedge clk) disable iff (!rst_n)
      wake |-> $past(armed))
      else $error("wake outside power-down");
endmodule // ipm_wake
